// file: logic/mnh_pkg.sv
package mnh_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_EFLAGS_IMG    = 8'h00;
	localparam logic [7:0]  IDX_FAULT_CTX     = 8'h01;
	localparam logic [7:0]  IDX_STATUS        = 8'h02;
	localparam logic [7:0]  IDX_CFG_C2        = 8'hC2;
	localparam logic [7:0]  IDX_CFG_E8        = 8'hE8;

	// Field positions
	localparam int          NEST_ALLOW_POS    = 6;
	localparam int          HALT_SUSPEND_REQUEST_N_POS     = 3;
	localparam int          IRQ_EN_POS        = 9;
	localparam int          CTX_IDT_LSB       = 0;
	localparam int          CTX_SP_LSB        = 16;
	localparam int          ST_STATE_LSB      = 0;
	localparam int          ST_NESTED_POS     = 4;
	localparam int          ST_NEST_ALLOW_POS = 5;
	localparam int          ST_EXT_PEND_POS   = 6;
	localparam int          ST_NMI_PEND_POS   = 7;
	localparam int          ST_MASKABLE_IRQ_PEND_POS  = 8;
	localparam int          ST_DFAULT_POS     = 9;
	localparam int          ST_DEPTH_LSB      = 12;

	// Reset values
	localparam logic        NEST_ALLOW_RST    = 1'b1;
	localparam logic        NESTED_RST        = 1'b0;
	localparam logic        HALT_SUSPEND_REQUEST_N_RST     = 1'b0;
	localparam logic        IRQ_EN_RST        = 1'b0;
	localparam logic [15:0] IDT_LIMIT_RST     = 16'h0000;
	localparam logic [15:0] SP_RST            = 16'h0000;

	// Shutdown escape thresholds
	localparam logic [15:0] IDT_LIMIT_MIN     = 16'h000F;
	localparam logic [15:0] SP_FLOOR          = 16'h0005;

	typedef enum logic [3:0] {
		MNH_RUN,
		MNH_HALT,
		MNH_SUSPEND_REQUEST_N_HW,
		MNH_MGMT,
		MNH_MGMT_HALT,
		MNH_MGMT_SUSPEND_REQUEST_N,
		MNH_RSM_WAIT,
		MNH_SHUTDOWN
	} mnh_state_t;

	typedef enum logic [2:0] {
		MNH_SEL_NONE,
		MNH_SEL_EFLAGS,
		MNH_SEL_CTX,
		MNH_SEL_STATUS,
		MNH_SEL_C2,
		MNH_SEL_E8
	} mnh_sel_t;

endpackage

// file: logic/mnh_hdr_mem.sv
`timescale 1ns/1ns
// Per-level save area for the nested status bit of each header
module mnh_hdr_mem #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic          clk_sys,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic          wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic               rd_data
);
	logic mem [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule // mnh_hdr_mem

// file: logic/mnh_ctrl.sv
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// - Bit 6 of config E8h gates acceptance of a new SYSTEM_MANAGEMENT_IRQ while in management state.
// - SYSTEM_MANAGEMENT_IRQ taken while already in management state sets the nested flag.
// - Resume uses the restored nested flag to stay in or leave management state.
// - Nesting off holds external SYSTEM_MANAGEMENT_IRQ until handler exits; nesting on takes it.
// - Internal SYSTEM_MANAGEMENT_IRQ events during management state are dropped.
// - Simultaneous internal and external SYSTEM_MANAGEMENT_IRQ: internal first, external stays pending.
// - Outside management state nested flag is clear and nest-allow is high.
// - Accepting an SYSTEM_MANAGEMENT_IRQ clears nest-allow, saves old nested flag, sets nested flag.
// - Resume sets nest-allow and reloads nested flag from the saved header.
// - In management or pin suspend, NMI and MASKABLE_IRQ latch; MASKABLE_IRQ only when IF set.
// - Handler suspends via halt or via the suspend request pin going low.
// - SYSTEM_MANAGEMENT_IRQ during halt from ordinary code leaves halt and enters management state.
// - Pin suspend from ordinary code latches one each of MASKABLE_IRQ, NMI and SYSTEM_MANAGEMENT_IRQ.
// - Halt issues a halt cycle; with C2h bit 3 also stop grant and low power.
// - Halt exits on SYSTEM_MANAGEMENT_IRQ, NMI, reset, or MASKABLE_IRQ with IF set.
// - Interrupted halt resumes at the instruction after the halt.
// - A fault while handling a double fault enters shutdown.
// - Shutdown exits on reset, or NMI with IDT limit >= 000Fh and SP > 0005h.
module mnh_ctrl
	import mnh_pkg::*;
#(
	parameter int HDR_DEPTH = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        sys_mgmt_irq_n,
	input  wire logic        suspend_request_n,
	input  wire logic        nonmaskable_irq,
	input  wire logic        maskable_irq,
	input  wire logic        internal_smi_evt,
	input  wire logic        halt_instr_exec,
	input  wire logic        resume_instr_exec,
	input  wire logic        double_fault_evt,
	input  wire logic        double_fault_done,
	input  wire logic        fault_evt,
	output logic             mgmt_active,
	output logic             nested_flag,
	output logic             nest_allow_bit,
	output logic             halt_cycle,
	output logic             stop_grant_cycle,
	output logic             low_power,
	output logic             shutdown_active,
	output logic             smi_service,
	output logic             nmi_service,
	output logic             maskable_irq_service,
	output logic             resume_after_halt
);
	localparam int AW = (HDR_DEPTH > 1) ? $clog2(HDR_DEPTH) : 1;

	function automatic mnh_sel_t reg_decode(input logic [31:0] a);
		mnh_sel_t s;
		s = MNH_SEL_NONE;
		if (a[31:10] != 22'h000000 || a[1:0] != 2'b00) begin
			s = MNH_SEL_NONE;
		end else if (a[9:2] == IDX_EFLAGS_IMG) begin
			s = MNH_SEL_EFLAGS;
		end else if (a[9:2] == IDX_FAULT_CTX) begin
			s = MNH_SEL_CTX;
		end else if (a[9:2] == IDX_STATUS) begin
			s = MNH_SEL_STATUS;
		end else if (a[9:2] == IDX_CFG_C2) begin
			s = MNH_SEL_C2;
		end else if (a[9:2] == IDX_CFG_E8) begin
			s = MNH_SEL_E8;
		end
		return s;
	endfunction

	mnh_state_t  state_q, state_d;
	logic        nested_q, nest_allow_q, halt_suspend_request_n_q, irq_en_q;
	logic [15:0] idt_limit_q, sp_q;
	logic        ext_pend_q, nmi_pend_q, maskable_irq_pend_q, dfault_q;
	logic        smi_n_q, nmi_q;
	logic [AW:0] depth_q;
	logic        wr_pend_q;
	mnh_sel_t    wr_sel_q;
	logic [31:0] hrdata_q;
	logic        halt_cycle_q, stop_grant_q, low_power_q, resume_after_q;
	logic        smi_svc_q, nmi_svc_q, maskable_irq_svc_q;
	logic        hdr_rd_data;
	logic        in_mgmt_q, shutdown_q;

	logic        addr_phase, smi_fall, nmi_rise;
	logic        in_mgmt, int_take, ext_take, take, svc_ok, nmi_now, maskable_irq_now;
	logic        halt_wake, shut_escape, rsm_start, triple;
	logic        e8_wr, c2_wr, fl_wr, ctx_wr;
	logic [31:0] status_w;

	assign addr_phase  = hsel && hready && htrans[1];
	assign smi_fall    = smi_n_q && !sys_mgmt_irq_n;
	assign nmi_rise    = nonmaskable_irq && !nmi_q;
	assign in_mgmt     = (state_q == MNH_MGMT) || (state_q == MNH_MGMT_HALT) ||
	                     (state_q == MNH_MGMT_SUSPEND_REQUEST_N) || (state_q == MNH_RSM_WAIT);

	// Internal events only count in run or ordinary halt state, not in management, pin suspend or shutdown
	assign int_take    = internal_smi_evt && (state_q == MNH_RUN || state_q == MNH_HALT);
	// Internal wins the slot; external stays pending for a later cycle
	assign ext_take    = ext_pend_q && !int_take && (
	                     state_q == MNH_RUN || state_q == MNH_HALT ||
	                     ((state_q == MNH_MGMT || state_q == MNH_MGMT_HALT) &&
	                      nest_allow_q));
	assign take        = int_take || ext_take;
	assign rsm_start   = (state_q == MNH_MGMT) && resume_instr_exec && !take;
	assign triple      = fault_evt && dfault_q;
	assign halt_wake   = nmi_pend_q || (maskable_irq_pend_q && irq_en_q);
	assign shut_escape = nmi_pend_q && (idt_limit_q >= IDT_LIMIT_MIN) &&
	                     (sp_q > SP_FLOOR);

	// Latched requests are only delivered to ordinary code
	assign svc_ok      = (state_q == MNH_RUN) && !take;
	assign nmi_now     = svc_ok && nmi_pend_q;
	assign maskable_irq_now    = svc_ok && !nmi_pend_q && maskable_irq_pend_q && irq_en_q;

	assign e8_wr  = wr_pend_q && (wr_sel_q == MNH_SEL_E8);
	assign c2_wr  = wr_pend_q && (wr_sel_q == MNH_SEL_C2);
	assign fl_wr  = wr_pend_q && (wr_sel_q == MNH_SEL_EFLAGS);
	assign ctx_wr = wr_pend_q && (wr_sel_q == MNH_SEL_CTX);

	always_comb begin
		status_w = 32'h00000000;
		status_w[ST_STATE_LSB +: 4]     = state_q;
		status_w[ST_NESTED_POS]         = nested_q;
		status_w[ST_NEST_ALLOW_POS]     = nest_allow_q;
		status_w[ST_EXT_PEND_POS]       = ext_pend_q;
		status_w[ST_NMI_PEND_POS]       = nmi_pend_q;
		status_w[ST_MASKABLE_IRQ_PEND_POS]      = maskable_irq_pend_q;
		status_w[ST_DFAULT_POS]         = dfault_q;
		status_w[ST_DEPTH_LSB +: AW+1]  = depth_q;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			MNH_RUN: begin
				if (take) begin
					state_d = MNH_MGMT;
				end else if (triple) begin
					state_d = MNH_SHUTDOWN;
				end else if (halt_instr_exec) begin
					state_d = MNH_HALT;
				end else if (!suspend_request_n) begin
					state_d = MNH_SUSPEND_REQUEST_N_HW;
				end
			end
			MNH_HALT: begin
				if (take) begin
					state_d = MNH_MGMT;
				end else if (halt_wake) begin
					state_d = MNH_RUN;
				end
			end
			MNH_SUSPEND_REQUEST_N_HW: begin
				if (suspend_request_n) begin
					state_d = MNH_RUN;
				end
			end
			MNH_MGMT: begin
				if (take) begin
					state_d = MNH_MGMT;
				end else if (triple) begin
					state_d = MNH_SHUTDOWN;
				end else if (resume_instr_exec) begin
					state_d = MNH_RSM_WAIT;
				end else if (halt_instr_exec) begin
					state_d = MNH_MGMT_HALT;
				end else if (!suspend_request_n) begin
					state_d = MNH_MGMT_SUSPEND_REQUEST_N;
				end
			end
			MNH_MGMT_HALT: begin
				if (take || halt_wake) begin
					state_d = MNH_MGMT;
				end
			end
			MNH_MGMT_SUSPEND_REQUEST_N: begin
				if (suspend_request_n) begin
					state_d = MNH_MGMT;
				end
			end
			MNH_RSM_WAIT: begin
				state_d = hdr_rd_data ? MNH_MGMT : MNH_RUN;
			end
			MNH_SHUTDOWN: begin
				if (shut_escape) begin
					state_d = MNH_RUN;
				end
			end
			default: begin
				state_d = MNH_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= MNH_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			smi_n_q <= 1'b1;
			nmi_q   <= 1'b0;
		end else begin
			smi_n_q <= sys_mgmt_irq_n;
			nmi_q   <= nonmaskable_irq;
		end
	end

	// A new edge in the cycle of delivery keeps the request pending
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_pend_q  <= 1'b0;
			nmi_pend_q  <= 1'b0;
			maskable_irq_pend_q <= 1'b0;
		end else begin
			ext_pend_q  <= smi_fall || (ext_pend_q && !ext_take);
			nmi_pend_q  <= nmi_rise || (nmi_pend_q && !nmi_now);
			maskable_irq_pend_q <= (maskable_irq && irq_en_q) ||
			               (maskable_irq_pend_q && !maskable_irq_now);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dfault_q <= 1'b0;
		end else if (double_fault_evt) begin
			dfault_q <= 1'b1;
		end else if (double_fault_done || state_q == MNH_SHUTDOWN) begin
			dfault_q <= 1'b0;
		end
	end

	// Depth saturates; a deeper nest than the save area overwrites the top slot
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			depth_q <= '0;
		end else if (take && depth_q != (AW+1)'(HDR_DEPTH)) begin
			depth_q <= depth_q + (AW+1)'(1);
		end else if (state_q == MNH_RSM_WAIT && depth_q != '0) begin
			depth_q <= depth_q - (AW+1)'(1);
		end else if (state_q == MNH_SHUTDOWN) begin
			depth_q <= '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nested_q <= NESTED_RST;
		end else if (take) begin
			nested_q <= 1'b1;
		end else if (state_q == MNH_RSM_WAIT) begin
			nested_q <= hdr_rd_data;
		end else if (!in_mgmt) begin
			nested_q <= 1'b0;
		end
	end

	// Hardware transitions win over a software write in the same cycle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			nest_allow_q <= NEST_ALLOW_RST;
		end else if (take) begin
			nest_allow_q <= 1'b0;
		end else if (state_q == MNH_RSM_WAIT) begin
			nest_allow_q <= 1'b1;
		end else if (!in_mgmt) begin
			nest_allow_q <= 1'b1;
		end else if (e8_wr) begin
			nest_allow_q <= hwdata[NEST_ALLOW_POS];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			halt_suspend_request_n_q <= HALT_SUSPEND_REQUEST_N_RST;
			irq_en_q    <= IRQ_EN_RST;
			idt_limit_q <= IDT_LIMIT_RST;
			sp_q        <= SP_RST;
		end else begin
			if (c2_wr) begin
				halt_suspend_request_n_q <= hwdata[HALT_SUSPEND_REQUEST_N_POS];
			end
			if (fl_wr) begin
				irq_en_q <= hwdata[IRQ_EN_POS];
			end
			if (ctx_wr) begin
				idt_limit_q <= hwdata[CTX_IDT_LSB +: 16];
				sp_q        <= hwdata[CTX_SP_LSB +: 16];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			halt_cycle_q   <= 1'b0;
			stop_grant_q   <= 1'b0;
			low_power_q    <= 1'b0;
			resume_after_q <= 1'b0;
			smi_svc_q      <= 1'b0;
			nmi_svc_q      <= 1'b0;
			maskable_irq_svc_q     <= 1'b0;
		end else begin
			halt_cycle_q   <= halt_instr_exec && !take &&
			                  (state_q == MNH_RUN || state_q == MNH_MGMT);
			stop_grant_q   <= halt_cycle_q && halt_suspend_request_n_q;
			low_power_q    <= (state_d == MNH_HALT || state_d == MNH_MGMT_HALT) &&
			                  halt_suspend_request_n_q;
			resume_after_q <= (state_q == MNH_HALT || state_q == MNH_MGMT_HALT) &&
			                  (take || halt_wake);
			smi_svc_q      <= take;
			nmi_svc_q      <= nmi_now;
			maskable_irq_svc_q     <= maskable_irq_now;
		end
	end

	// Old nested flag goes into the save slot of the new level
	mnh_hdr_mem #(
		.DEPTH (HDR_DEPTH),
		.AW    (AW)
	) u_hdr (
		.clk_sys (clk_sys),
		.wr_en   (take),
		.wr_addr (depth_q[AW-1:0] - AW'(depth_q == (AW+1)'(HDR_DEPTH))),
		.wr_data (nested_q),
		.rd_en   (rsm_start),
		.rd_addr (depth_q[AW-1:0] - AW'(1)),
		.rd_data (hdr_rd_data)
	);

	// Zero-wait slave: reads answer in the data phase, writes land then
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			wr_sel_q  <= MNH_SEL_NONE;
			hrdata_q  <= 32'h00000000;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			wr_sel_q  <= reg_decode(haddr);
			if (addr_phase && !hwrite) begin
				case (reg_decode(haddr))
					MNH_SEL_EFLAGS: hrdata_q <= 32'(irq_en_q) << IRQ_EN_POS;
					MNH_SEL_CTX:    hrdata_q <= {sp_q, idt_limit_q};
					MNH_SEL_STATUS: hrdata_q <= status_w;
					MNH_SEL_C2:     hrdata_q <= 32'(halt_suspend_request_n_q) << HALT_SUSPEND_REQUEST_N_POS;
					MNH_SEL_E8:     hrdata_q <= 32'(nest_allow_q) << NEST_ALLOW_POS;
					default:        hrdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign hrdata            = hrdata_q;
	assign hreadyout         = 1'b1;
	assign hresp             = 1'b0;
	assign mgmt_active       = in_mgmt_q;
	assign nested_flag       = nested_q;
	assign nest_allow_bit    = nest_allow_q;
	assign halt_cycle        = halt_cycle_q;
	assign stop_grant_cycle  = stop_grant_q;
	assign low_power         = low_power_q;
	assign shutdown_active   = shutdown_q;
	assign smi_service       = smi_svc_q;
	assign nmi_service       = nmi_svc_q;
	assign maskable_irq_service      = maskable_irq_svc_q;
	assign resume_after_halt = resume_after_q;

	// Registered from the next state so the flags line up with state_q
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			in_mgmt_q  <= 1'b0;
			shutdown_q <= 1'b0;
		end else begin
			in_mgmt_q  <= (state_d == MNH_MGMT) || (state_d == MNH_MGMT_HALT) ||
			              (state_d == MNH_MGMT_SUSPEND_REQUEST_N) || (state_d == MNH_RSM_WAIT);
			shutdown_q <= (state_d == MNH_SHUTDOWN);
		end
	end
endmodule // mnh_ctrl

// file: verif/mnh_chipset_model.sv
`timescale 1ns/1ns
module mnh_chipset_model (
	input  wire logic clk_sys,
	output logic      sys_mgmt_irq_n,
	output logic      suspend_request_n,
	output logic      nonmaskable_irq,
	output logic      maskable_irq
);
	initial begin
		sys_mgmt_irq_n    = 1'b1;
		suspend_request_n = 1'b1;
		nonmaskable_irq   = 1'b0;
		maskable_irq      = 1'b0;
	end

	// Low for two cycles so the falling edge is seen past the input register
	task automatic smi_pulse();
		@(posedge clk_sys) sys_mgmt_irq_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		sys_mgmt_irq_n <= 1'b1;
	endtask

	task automatic nmi_pulse();
		@(posedge clk_sys) nonmaskable_irq <= 1'b1;
		@(posedge clk_sys) nonmaskable_irq <= 1'b0;
	endtask

	task automatic set_maskable_irq(input logic v);
		@(posedge clk_sys) maskable_irq <= v;
	endtask

	task automatic set_suspend_request_n(input logic v);
		@(posedge clk_sys) suspend_request_n <= v;
	endtask
endmodule // mnh_chipset_model

// file: verif/mnh_ctrl_checker.sv
`timescale 1ns/1ns
module mnh_ctrl_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic nonmaskable_irq,
	input wire logic halt_instr_exec,
	input wire logic resume_instr_exec,
	input wire logic mgmt_active,
	input wire logic nested_flag,
	input wire logic nest_allow_bit,
	input wire logic halt_cycle,
	input wire logic stop_grant_cycle,
	input wire logic low_power,
	input wire logic shutdown_active,
	input wire logic smi_service
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	reset_flags_a:
		assert property ($fell(rst) |-> nest_allow_bit && !nested_flag)
		else $error("Flags not at reset values");
	out_mgmt_a:
		assert property (!mgmt_active && !$past(mgmt_active) |-> !nested_flag && nest_allow_bit)
		else $error("Flags wrong outside management");
	smi_entry_a:
		assert property (smi_service |-> mgmt_active && nested_flag && !nest_allow_bit)
		else $error("Flags wrong on interrupt entry");
	no_nest_take_a:
		assert property (mgmt_active && !nest_allow_bit |=> !smi_service)
		else $error("Interrupt taken with nesting off");
	resume_flags_a:
		assert property (resume_instr_exec && mgmt_active
			|-> ##2 nest_allow_bit ##1 (!$past(nested_flag) || mgmt_active))
		else $error("Resume flags or state wrong");
	halt_seq_a:
		assert property (halt_instr_exec && !mgmt_active && !shutdown_active
			|=> halt_cycle ##1 (stop_grant_cycle == low_power))
		else $error("Halt cycle sequence wrong");
	stop_grant_a:
		assert property (stop_grant_cycle |-> $past(halt_cycle))
		else $error("Stop grant without halt cycle");
	shut_hold_a:
		assert property (shutdown_active && !nonmaskable_irq && !$past(nonmaskable_irq)
			&& !$past(nonmaskable_irq, 2) |=> shutdown_active)
		else $error("Shutdown left without cause");

	cover property (smi_service && $past(mgmt_active));
	cover property (stop_grant_cycle);
	cover property ($fell(shutdown_active));
	cover property (resume_instr_exec && nested_flag);
endmodule // mnh_ctrl_checker

bind mnh_ctrl mnh_ctrl_checker u_mnh_ctrl_checker (.clk_sys, .rst, .nonmaskable_irq,
	.halt_instr_exec, .resume_instr_exec, .mgmt_active, .nested_flag, .nest_allow_bit,
	.halt_cycle, .stop_grant_cycle, .low_power, .shutdown_active, .smi_service);

// file: verif/mnh_ctrl_tb.sv
`timescale 1ns/1ns
module mnh_ctrl_tb;
	import mnh_pkg::*;
	localparam logic [31:0] A_EFL = {22'h0, IDX_EFLAGS_IMG, 2'h0};
	localparam logic [31:0] A_CTX = {22'h0, IDX_FAULT_CTX, 2'h0};
	localparam logic [31:0] A_ST  = {22'h0, IDX_STATUS, 2'h0};
	localparam logic [31:0] A_C2  = {22'h0, IDX_CFG_C2, 2'h0};
	localparam logic [31:0] A_E8  = {22'h0, IDX_CFG_E8, 2'h0};
	localparam logic [5:0]  E_INT = 6'h01;
	localparam logic [5:0]  E_HLT = 6'h02;
	localparam logic [5:0]  E_RES = 6'h04;
	localparam logic [5:0]  E_DF  = 6'h08;
	localparam logic [5:0]  E_DON = 6'h10;
	localparam logic [5:0]  E_FLT = 6'h20;

	logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [5:0]  ev;
	logic        sys_mgmt_irq_n, suspend_request_n, nonmaskable_irq, maskable_irq;
	logic        mgmt_active, nested_flag, nest_allow_bit, halt_cycle, stop_grant_cycle;
	logic        low_power, shutdown_active, smi_service, nmi_service, maskable_irq_service;
	logic        resume_after_halt;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cnt [4] = '{0, 0, 0, 0};

	mnh_ctrl u_mnh_ctrl (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .sys_mgmt_irq_n,
		.suspend_request_n, .nonmaskable_irq, .maskable_irq, .internal_smi_evt(ev[0]),
		.halt_instr_exec(ev[1]), .resume_instr_exec(ev[2]), .double_fault_evt(ev[3]),
		.double_fault_done(ev[4]), .fault_evt(ev[5]), .mgmt_active, .nested_flag,
		.nest_allow_bit, .halt_cycle, .stop_grant_cycle, .low_power, .shutdown_active,
		.smi_service, .nmi_service, .maskable_irq_service, .resume_after_halt);

	mnh_chipset_model u_mnh_chipset_model (.clk_sys, .sys_mgmt_irq_n, .suspend_request_n,
		.nonmaskable_irq, .maskable_irq);

	always #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cnt[0] <= cnt[0] + int'(smi_service);
		cnt[1] <= cnt[1] + int'(nmi_service);
		cnt[2] <= cnt[2] + int'(maskable_irq_service);
		cnt[3] <= cnt[3] + int'(resume_after_halt);
	end

	task automatic results();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wait_rdy();
		int i;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin
			chk("bus ready", 32'h1, 32'h0);
			results();
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		hsize <= 3'h2;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hsize <= 3'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input string what, input logic [31:0] a, exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask

	task automatic pulse(input logic [5:0] m);
		@(posedge clk_sys) ev <= m;
		@(posedge clk_sys) ev <= 6'h0;
	endtask

	task automatic wait_ev(input int k, input string what);
		int c0;
		int i;
		c0 = cnt[k];
		for (i = 0; i < 20 && cnt[k] == c0; i++)
			@(posedge clk_sys);
		chk(what, c0 + 1, cnt[k]);
		if (cnt[k] == c0)
			results();
	endtask

	// Handler clears nesting before resume, as software must
	task automatic leave();
		wr(A_E8, 32'h0);
		pulse(E_RES);
		cyc(3);
	endtask

	task automatic do_reset();
		@(posedge clk_sys) rst <= 1'b1;
		cyc(10);
		rst <= 1'b0;
		cyc(1);
	endtask

	task automatic t_reset();
		chk("nest_allow", 32'h1, nest_allow_bit);
		chk("nested", 32'h0, nested_flag);
		chk("hresp", 32'h0, hresp);
		rdchk("status", A_ST, 32'h1 << ST_NEST_ALLOW_POS);
		rdchk("unmapped", 32'h0000_00FC, 32'h0);
	endtask

	task automatic t_nest();
		int c;
		u_mnh_chipset_model.smi_pulse();
		wait_ev(0, "first smi");
		chk("nested", 32'h1, nested_flag);
		chk("nest_allow", 32'h0, nest_allow_bit);
		c = cnt[0];
		pulse(E_INT);
		u_mnh_chipset_model.smi_pulse();
		cyc(6);
		chk("held smi", c, cnt[0]);
		wr(A_E8, 32'h1 << NEST_ALLOW_POS);
		wait_ev(0, "nested smi");
		chk("nested", 32'h1, nested_flag);
		leave();
		chk("stay mgmt", 32'h1, mgmt_active);
		chk("nest_allow", 32'h1, nest_allow_bit);
		chk("nested", 32'h1, nested_flag);
		leave();
		chk("left mgmt", 32'h0, mgmt_active);
		chk("nested", 32'h0, nested_flag);
	endtask

	task automatic t_simul();
		int c;
		c = cnt[0];
		fork
			u_mnh_chipset_model.smi_pulse();
			begin
				cyc(1);
				pulse(E_INT);
			end
		join
		cyc(6);
		chk("one smi", c + 1, cnt[0]);
		leave();
		cyc(6);
		chk("pending smi", c + 2, cnt[0]);
		leave();
		chk("left mgmt", 32'h0, mgmt_active);
	endtask

	task automatic t_halt();
		wr(A_C2, 32'h1 << HALT_SUSPEND_REQUEST_N_POS);
		wr(A_EFL, 32'h0);
		pulse(E_HLT);
		cyc(1);
		chk("halt cycle", 32'h1, halt_cycle);
		cyc(1);
		chk("stop grant", 32'h1, stop_grant_cycle);
		chk("low power", 32'h1, low_power);
		u_mnh_chipset_model.set_maskable_irq(1'b1);
		cyc(5);
		chk("maskable_irq masked", 32'h1, low_power);
		u_mnh_chipset_model.set_maskable_irq(1'b0);
		u_mnh_chipset_model.nmi_pulse();
		wait_ev(3, "halt exit nmi");
		wr(A_EFL, 32'h1 << IRQ_EN_POS);
		pulse(E_HLT);
		cyc(3);
		u_mnh_chipset_model.set_maskable_irq(1'b1);
		wait_ev(3, "halt exit maskable_irq");
		u_mnh_chipset_model.set_maskable_irq(1'b0);
		pulse(E_HLT);
		cyc(3);
		u_mnh_chipset_model.smi_pulse();
		wait_ev(0, "halt exit smi");
		chk("mgmt from halt", 32'h1, mgmt_active);
		leave();
	endtask

	// Handler suspends by halt and by the pin; latched NMI waits for ordinary code
	task automatic t_msusp();
		int c;
		logic [31:0] base;
		c = cnt[1];
		base = (32'h1 << ST_DEPTH_LSB) | (32'h1 << ST_NESTED_POS);
		u_mnh_chipset_model.smi_pulse();
		wait_ev(0, "smi for handler");
		pulse(E_HLT);
		cyc(2);
		rdchk("mgmt halt", A_ST, base | 32'(MNH_MGMT_HALT));
		u_mnh_chipset_model.nmi_pulse();
		cyc(3);
		chk("halt wake in mgmt", 32'h0, low_power);
		u_mnh_chipset_model.set_suspend_request_n(1'b0);
		cyc(2);
		base = base | (32'h1 << ST_NMI_PEND_POS);
		rdchk("mgmt suspend_request_n", A_ST, base | 32'(MNH_MGMT_SUSPEND_REQUEST_N));
		chk("nmi held in mgmt", c, cnt[1]);
		u_mnh_chipset_model.set_suspend_request_n(1'b1);
		cyc(2);
		leave();
		cyc(3);
		chk("nmi after resume", c + 1, cnt[1]);
	endtask

	task automatic t_suspend_request_n();
		int c;
		int d;
		c = cnt[1];
		d = cnt[2];
		u_mnh_chipset_model.set_suspend_request_n(1'b0);
		u_mnh_chipset_model.nmi_pulse();
		u_mnh_chipset_model.nmi_pulse();
		u_mnh_chipset_model.set_maskable_irq(1'b1);
		u_mnh_chipset_model.set_maskable_irq(1'b0);
		cyc(4);
		chk("nmi held", c, cnt[1]);
		u_mnh_chipset_model.set_suspend_request_n(1'b1);
		cyc(20);
		chk("nmi once", c + 1, cnt[1]);
		chk("maskable_irq once", d + 1, cnt[2]);
	endtask

	task automatic t_shut();
		logic [15:0] lim [3] = '{16'h000E, 16'h000F, 16'h000F};
		logic [15:0] sp [3] = '{16'h0006, 16'h0005, 16'h0006};
		int i;
		pulse(E_DF);
		pulse(E_DON);
		pulse(E_FLT);
		cyc(1);
		chk("fault after done", 32'h0, shutdown_active);
		for (i = 0; i < 3; i++) begin
			wr(A_CTX, {sp[i], lim[i]});
			pulse(E_DF);
			pulse(E_FLT);
			cyc(1);
			chk("shutdown entry", 32'h1, shutdown_active);
			u_mnh_chipset_model.nmi_pulse();
			cyc(8);
			chk("shutdown nmi", (i == 2) ? 32'h0 : 32'h1, shutdown_active);
			do_reset();
			chk("shutdown reset", 32'h0, shutdown_active);
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hsize = 3'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ev = 6'h0;
		do_reset();
		t_reset();
		t_nest();
		t_simul();
		t_halt();
		t_msusp();
		t_suspend_request_n();
		t_shut();
		results();
	end
endmodule // mnh_ctrl_tb
